// ===== rtl/csc_counter.v
// Purpose: capacitive sense counter: two 8-bit capture counters, chainable,
//          a 6-bit one-shot down timer, event modes and clock selection
// Assumes: all analog and oscillator inputs are sampled on clk
// Notes:   registers are reached over Avalon-MM with one wait cycle
//
// Summary of operation
// - two 8-bit counters, chainable, plus 6-bit timer
// - comparator gates chained counter, trip captures
// - one-shot capture freezes counters for reading
// - low on count clock, high on oscillator
// - timer on oscillator, chained counter on count clock
// - timer starts on synchronized enable, once
// - timer clock chosen by pin drive enable
// - timer terminal count pulse one timer cycle
// - low time equals loaded count periods
// - output select routes event, interrupt, carries
// - switch clock: prescaled clock or sequencer
// - count clock source: main or prescaled clock
// - sigma delta gates counting, timer on prescaled
// - mode 00 stops on selected interrupt event
// - mode 01 measures rising to falling edge
// - mode 10 measures rising to rising edge
// - mode 11 periodic carry every 100h/10000h
// - enable starts; disable clears unless event-held
// - chain bit joins counters into 16 bits
// - three-bit select picks event source
// - high counter on oscillator when bit set and chain clear
// - polarity flip inverts selected input
// - sticky status, cleared by zero, cleared disabled
`timescale 1ns/1ps
`include "csc_map.vh"

module csc_counter (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// avalon-mm slave
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// sensing inputs
	input  wire        cmp0_in,
	input  wire        cmp1_in,
	input  wire        relaxation_oscillator_in,
	input  wire        low_speed_oscillator_in,
	input  wire        mux_bus_in,
	input  wire        pseudo_random_sequencer_in,
	input  wire        pit_start_in,
	input  wire        internal_timer_in,
	// outputs
	output reg         pin_out,
	output reg         switch_clk,
	output reg         pit_on_prescaled,
	output reg         timer_tc
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_ARM  = 4'b0010;
	localparam ST_RUN  = 4'b0100;
	localparam ST_DONE = 4'b1000;

	reg  [7:0]  ctrl_pri_r;
	reg  [7:0]  ctrl_sec_r;
	reg         pxd_r;
	reg  [5:0]  tmr_load_r;
	reg  [3:0]  stat_r;
	reg  [3:0]  mask_r;
	reg  [7:0]  cnt_lo_r;
	reg  [7:0]  cnt_hi_r;
	reg  [3:0]  st_r;
	reg         hold_r;
	reg         en_prev_r;
	reg         ev_prev_r;
	reg         osc_prev_r;
	reg  [7:0]  psc_cnt_r;
	reg         psc_clk_r;
	reg  [2:0]  div_cnt_r;
	reg         tsync1_r;
	reg         tsync2_r;
	reg         t_started_r;
	reg         t_running_r;
	reg  [5:0]  t_cnt_r;
	reg         t_irq_r;
	reg  [31:0] rd_mux;
	reg  [2:0]  div_mask;
	reg         ev_sel;
	reg  [3:0]  st_nxt;
	reg         pin_nxt;
	wire [7:0]  raw_in;
	wire [7:0]  sync_s;

	// control field aliases
	wire        en       = ctrl_pri_r[`CSC_PRI_EN];
	wire [1:0]  mode     = ctrl_pri_r[`CSC_PRI_MODE_LSB +: 2];
	wire        sd_en    = ctrl_pri_r[`CSC_PRI_SD_EN];
	wire        cnt_src  = ctrl_pri_r[`CSC_PRI_CNT_SRC];
	wire        sw_sel   = ctrl_pri_r[`CSC_PRI_SW_SEL];
	wire [1:0]  out_sel  = ctrl_pri_r[`CSC_PRI_OUT_LSB +: 2];
	wire [2:0]  in_sel   = ctrl_sec_r[`CSC_SEC_INSEL_LSB +: 3];
	wire        flip     = ctrl_sec_r[`CSC_SEC_FLIP];
	wire        hi_osc   = ctrl_sec_r[`CSC_SEC_HI_OSC];
	wire [1:0]  div_sel  = ctrl_sec_r[`CSC_SEC_DIV_LSB +: 2];
	wire        chain    = ctrl_sec_r[`CSC_SEC_CHAIN];

	assign raw_in = {internal_timer_in, pit_start_in,
		pseudo_random_sequencer_in, mux_bus_in, low_speed_oscillator_in,
		relaxation_oscillator_in, cmp1_in, cmp0_in};

	// two-flop synchronisers, one per asynchronous input
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			reg s1_r;
			reg s2_r;
			always @(posedge clk) begin
				if (sys_rst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= raw_in[gi];
					s2_r <= s1_r;
				end
			end
			assign sync_s[gi] = s2_r;
		end
	endgenerate

	wire cmp0_s  = sync_s[0];
	wire cmp1_s  = sync_s[1];
	wire osc_s   = sync_s[2];
	wire lso_s   = sync_s[3];
	wire mux_s   = sync_s[4];
	wire seq_s   = sync_s[5];
	wire pit_s   = sync_s[6];
	wire itmr_s  = sync_s[7];
	wire osc_rise = osc_s & ~osc_prev_r;

	// bus handshake: a request is answered after one wait cycle
	wire req    = avs_read | avs_write;
	wire wr_go  = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire [7:0] wd = avs_writedata[7:0];
	wire wr_pri = wr_go & (avs_address == `CSC_IDX_CTRL_PRI);
	wire wr_sec = wr_go & (avs_address == `CSC_IDX_CTRL_SEC);
	wire wr_aux = wr_go & (avs_address == `CSC_IDX_CTRL_AUX);
	wire wr_sta = wr_go & (avs_address == `CSC_IDX_STATUS);
	wire wr_tmr = wr_go & (avs_address == `CSC_IDX_TIMER);

	// prescaled main clock, free running so it never stops mid-scan
	wire psc_tick = (psc_cnt_r == `CSC_PRESCALE_DIV - 8'h01);
	wire src_tick = cnt_src ? psc_tick : 1'b1;

	// divider mask per frequency select code
	always @* begin
		case (div_sel)
			2'h0:    div_mask = 3'h0;
			2'h1:    div_mask = 3'h1;
			2'h2:    div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end
	wire cnt_tick = src_tick & ((div_cnt_r & div_mask) == div_mask);

	wire tmr_tick = pxd_r ? cnt_tick : osc_rise;

	always @* begin
		case (in_sel)
			3'h0:    ev_sel = cmp0_s;
			3'h1:    ev_sel = lso_s;
			3'h2:    ev_sel = cmp1_s;
			3'h3:    ev_sel = timer_tc;
			3'h4:    ev_sel = itmr_s;
			3'h5:    ev_sel = t_irq_r;
			3'h6:    ev_sel = mux_s;
			default: ev_sel = 1'b0;
		endcase
	end
	wire ev_in   = ev_sel ^ flip;
	wire ev_rise = ev_in & ~ev_prev_r;
	wire ev_fall = ~ev_in & ev_prev_r;
	wire en_rise = en & ~en_prev_r;

	// comparator and interval timer gate counting
	wire gate    = cnt_tick & (~sd_en | (cmp0_s & pit_s));
	wire running = st_r[2];
	wire lo_tick = running & gate;
	wire lo_cy   = lo_tick & (cnt_lo_r == 8'hFF);
	// chained: high steps on low carry
	wire hi_tick = running & (chain ? lo_cy : (hi_osc ? osc_rise : gate));
	wire hi_cy   = hi_tick & (cnt_hi_r == 8'hFF);

	// measurement completion in the edge modes
	wire pp_ev = running &
		(((mode == `CSC_MODE_PWIDTH) & ev_fall) |
		 ((mode == `CSC_MODE_PERIOD) & ev_rise));
	// status events: input, low carry, high carry, pulse/period
	wire [3:0] evs    = {ev_rise & (running | st_r[1]), lo_cy, hi_cy, pp_ev};
	wire       sel_ev = |(evs & mask_r);
	wire       cs_int = |(stat_r & mask_r);

	// mode sequencer
	always @* begin
		st_nxt = st_r;
		if (!en) begin
			st_nxt = ST_IDLE;
		end else begin
			case (st_r)
				ST_IDLE: begin
					// edge modes wait for a rising edge
					if (mode == `CSC_MODE_PWIDTH || mode == `CSC_MODE_PERIOD)
						st_nxt = ST_ARM;
					else
						st_nxt = ST_RUN;
				end
				ST_ARM: begin
					if (ev_rise)
						st_nxt = ST_RUN;
				end
				ST_RUN: begin
					if (mode == `CSC_MODE_STOP && sel_ev)
						st_nxt = ST_DONE;
					else if (pp_ev)
						st_nxt = ST_DONE;
				end
				ST_DONE: st_nxt = ST_DONE;
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	always @* begin
		case (out_sel)
			2'h0:    pin_nxt = ev_in;
			2'h1:    pin_nxt = cs_int;
			2'h2:    pin_nxt = lo_cy;
			default: pin_nxt = hi_cy;
		endcase
	end

	// register file, status and mask
	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl_pri_r <= `CSC_RST_CTRL_PRI;
			ctrl_sec_r <= `CSC_RST_CTRL_SEC;
			pxd_r      <= 1'b0;
			tmr_load_r <= `CSC_RST_TIMER;
			stat_r     <= 4'h0;
			mask_r     <= 4'h0;
		end else begin
			// writes while enabled are software's concern
			if (wr_pri)
				ctrl_pri_r <= wd;
			if (wr_sec)
				ctrl_sec_r <= wd;
			if (wr_aux)
				pxd_r <= wd[`CSC_AUX_PXD];
			if (wr_tmr)
				tmr_load_r <= wd[5:0];
			if (wr_sta)
				mask_r <= wd[3:0];
			// clear by zero, set wins, cleared when disabled
			if (!en)
				stat_r <= 4'h0;
			else if (wr_sta)
				stat_r <= (stat_r & wd[7:4]) | evs;
			else
				stat_r <= stat_r | evs;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_lo_r <= 8'h00;
			cnt_hi_r <= 8'h00;
			hold_r   <= 1'b0;
			st_r     <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
			if (st_nxt == ST_DONE)
				hold_r <= 1'b1;
			else if (en_rise)
				hold_r <= 1'b0;
			// a fresh enable or a plain disable clears the count
			if (en_rise || (!en && !hold_r)) begin
				cnt_lo_r <= 8'h00;
				cnt_hi_r <= 8'h00;
			end else begin
				if (lo_tick)
					cnt_lo_r <= cnt_lo_r + 8'h01;
				if (hi_tick)
					cnt_hi_r <= cnt_hi_r + 8'h01;
			end
		end
	end

	// clock generation and edge history
	always @(posedge clk) begin
		if (sys_rst) begin
			psc_cnt_r <= 8'h00;
			psc_clk_r <= 1'b0;
			div_cnt_r <= 3'h0;
			en_prev_r <= 1'b0;
			ev_prev_r <= 1'b0;
			osc_prev_r <= 1'b0;
		end else begin
			psc_cnt_r <= psc_tick ? 8'h00 : psc_cnt_r + 8'h01;
			if (psc_tick)
				psc_clk_r <= ~psc_clk_r;
			if (src_tick)
				div_cnt_r <= div_cnt_r + 3'h1;
			en_prev_r <= en;
			ev_prev_r <= ev_in;
			osc_prev_r <= osc_s;
		end
	end

	// 6-bit one-shot down timer, stepping on the timer clock
	always @(posedge clk) begin
		if (sys_rst) begin
			tsync1_r    <= 1'b0;
			tsync2_r    <= 1'b0;
			t_started_r <= 1'b0;
			t_running_r <= 1'b0;
			t_cnt_r     <= 6'h00;
			timer_tc    <= 1'b0;
			t_irq_r     <= 1'b0;
		end else begin
			if (!en)
				t_irq_r <= 1'b0;
			else if (timer_tc)
				t_irq_r <= 1'b1;
			if (tmr_tick) begin
				// enable double synchronised to timer domain
				tsync1_r <= en;
				tsync2_r <= tsync1_r;
				timer_tc <= 1'b0;
				if (!tsync2_r) begin
					t_started_r <= 1'b0;
					t_running_r <= 1'b0;
				end else if (!t_started_r) begin
					t_started_r <= 1'b1;
					t_cnt_r     <= tmr_load_r;
					if (tmr_load_r == 6'h00)
						timer_tc <= 1'b1;
					else
						t_running_r <= 1'b1;
				end else if (t_running_r) begin
					t_cnt_r <= t_cnt_r - 6'h01;
					if (t_cnt_r == 6'h01) begin
						timer_tc    <= 1'b1;
						t_running_r <= 1'b0;
					end
				end
			end
		end
	end

	// registered outputs
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_out          <= 1'b0;
			switch_clk       <= 1'b0;
			pit_on_prescaled <= 1'b0;
		end else begin
			pin_out          <= pin_nxt;
			switch_clk       <= sw_sel ? seq_s : psc_clk_r;
			// interval timer clocked from the prescaled clock
			pit_on_prescaled <= sd_en;
		end
	end

	// read-back mux; unmapped indices read zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			`CSC_IDX_CTRL_PRI: rd_mux[7:0] = ctrl_pri_r;
			`CSC_IDX_CTRL_SEC: rd_mux[7:0] = ctrl_sec_r;
			`CSC_IDX_CTRL_AUX: rd_mux[`CSC_AUX_PXD] = pxd_r;
			`CSC_IDX_CNT_LO:   rd_mux[7:0] = cnt_lo_r;
			`CSC_IDX_CNT_HI:   rd_mux[7:0] = cnt_hi_r;
			`CSC_IDX_STATUS:   rd_mux[7:0] = {stat_r, mask_r};
			`CSC_IDX_TIMER:    rd_mux[5:0] = tmr_load_r;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// avalon answer: waitrequest drops for one cycle after a request
	always @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

endmodule // csc_counter

// ===== rtl/csc_map.vh
// Purpose: register indices, field positions and reset values for the
//          capacitive sense counter
// Assumes: included by bare name from the design file
// Notes:   indices are word indices; byte address is four times the index
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

// register word indices
`define CSC_IDX_CTRL_PRI   8'hA0
`define CSC_IDX_CTRL_SEC   8'hA1
`define CSC_IDX_CTRL_AUX   8'hA2
`define CSC_IDX_CNT_LO     8'hA4
`define CSC_IDX_CNT_HI     8'hA5
`define CSC_IDX_STATUS     8'hA6
`define CSC_IDX_TIMER      8'hA7

// reset values
`define CSC_RST_CTRL_PRI   8'h00
`define CSC_RST_CTRL_SEC   8'h00
`define CSC_RST_CTRL_AUX   8'h00
`define CSC_RST_TIMER      6'h00

// counter_control_primary fields
`define CSC_PRI_EN         0
`define CSC_PRI_MODE_LSB   1
`define CSC_PRI_SD_EN      3
`define CSC_PRI_CNT_SRC    4
`define CSC_PRI_SW_SEL     5
`define CSC_PRI_OUT_LSB    6

// counter_control_secondary fields
`define CSC_SEC_INSEL_LSB  0
`define CSC_SEC_FLIP       3
`define CSC_SEC_HI_OSC     4
`define CSC_SEC_DIV_LSB    5
`define CSC_SEC_CHAIN      7

// auxiliary control field
`define CSC_AUX_PXD        2

// operating modes
`define CSC_MODE_STOP      2'h0
`define CSC_MODE_PWIDTH    2'h1
`define CSC_MODE_PERIOD    2'h2
`define CSC_MODE_CONT      2'h3

// prescaler for the prescaled main clock, in main clock cycles
`define CSC_PRESCALE_DIV   8'h02

`endif

// ===== test/csc_counter_asserts.sv
// Purpose: port-level checks for the capacitive sense counter
// Assumes: one clock, synchronous active-high reset
// Notes:   primary and secondary control registers are shadowed from accepted bus writes
`timescale 1ns/1ps
`include "csc_map.vh"
module csc_counter_asserts (
	// clock and reset
	input wire        clk,
	input wire        sys_rst,
	// register bus
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// watched inputs and outputs
	input wire        cmp0_in,
	input wire        pseudo_random_sequencer_in,
	input wire        pin_out,
	input wire        switch_clk,
	input wire        pit_on_prescaled,
	input wire        timer_tc
);
	reg  [7:0] pri_r;
	reg  [7:0] sec_r;
	reg  [2:0] quiet_r;
	reg  [3:0] seq_r;
	reg  [3:0] cmp_r;
	wire       wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire       wr_pri = wr_ok && avs_address == `CSC_IDX_CTRL_PRI;
	wire       wr_sec = wr_ok && avs_address == `CSC_IDX_CTRL_SEC;
	wire       rd_ok = avs_read && !avs_waitrequest;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// shadows; quiet counts edges since a config write, so that
	// registered outputs are only judged once the new setting settled
	always @(posedge clk) begin
		if (sys_rst) begin
			pri_r   <= `CSC_RST_CTRL_PRI;
			sec_r   <= `CSC_RST_CTRL_SEC;
			quiet_r <= 3'h0;
		end else begin
			if (wr_pri)
				pri_r <= avs_writedata[7:0];
			if (wr_sec)
				sec_r <= avs_writedata[7:0];
			if (wr_pri || wr_sec)
				quiet_r <= 3'h0;
			else if (quiet_r != 3'h7)
				quiet_r <= quiet_r + 3'h1;
		end
		seq_r <= {seq_r[2:0], pseudo_random_sequencer_in};
		cmp_r <= {cmp_r[2:0], cmp0_in};
	end

	a_wait_one:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_answer_next:
		assert property ((avs_read || avs_write) && avs_waitrequest
			|=> !avs_waitrequest) else $error("no answer");
	a_pri_read:
		assert property (rd_ok && avs_address == `CSC_IDX_CTRL_PRI
			|-> avs_readdata == {24'h0, pri_r}) else $error("bad read");
	a_sec_read:
		assert property (rd_ok && avs_address == `CSC_IDX_CTRL_SEC
			|-> avs_readdata == {24'h0, sec_r}) else $error("bad read");
	a_sd_copy:
		assert property (quiet_r != 3'h0 |-> pit_on_prescaled == pri_r[3])
		else $error("sigma delta flag wrong");
	a_switch_seq:
		assert property (pri_r[5] && quiet_r > 3'h3 && seq_r == {4{seq_r[0]}}
			|-> switch_clk == seq_r[0]) else $error("switch clock wrong");
	a_switch_pre:
		assert property (!pri_r[5] && quiet_r > 3'h2
			|-> switch_clk != $past(switch_clk, 2)) else $error("bad square");
	a_pin_event:
		assert property (pri_r[7:6] == 2'h0 && sec_r[2:0] == 3'h0
			&& quiet_r > 3'h3 && cmp_r == {4{cmp_r[0]}}
			|-> pin_out == (cmp_r[0] ^ sec_r[3])) else $error("pin wrong");

	// main scenarios reached
	c_carry: cover property (pri_r[7:6] == 2'h2 && $rose(pin_out));
	c_timer: cover property ($fell(timer_tc));
	c_read: cover property (rd_ok);
endmodule // csc_counter_asserts

bind csc_counter csc_counter_asserts u_chk (.clk, .sys_rst, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .cmp0_in, .pseudo_random_sequencer_in, .pin_out,
	.switch_clk, .pit_on_prescaled, .timer_tc);

// ===== test/csc_far_side.sv
// Purpose: comparator, oscillator and sequencer stand-in
// Assumes: bench opens oscillator frames with osc_run
// Notes:   oscillator rests low between frames, period eight clocks
`timescale 1ns/1ps
module csc_far_side (
	// clock
	input  wire       clk,
	// bench controls
	input  wire       osc_run,
	input  wire       cmp_lvl,
	// sensing side
	output wire       osc,
	output wire       cmp0,
	output wire       seq
);
	reg [2:0] osc_cnt_r = 3'h0;
	reg [3:0] seq_cnt_r = 4'h0;

	// comparator is always driven; sequencer toggles slowly
	assign cmp0 = cmp_lvl;
	assign seq = seq_cnt_r[3];
	assign osc = osc_cnt_r[2];
	// oscillator stops and rests low outside a frame
	always @(posedge clk) begin
		seq_cnt_r <= seq_cnt_r + 4'h1;
		osc_cnt_r <= osc_run ? osc_cnt_r + 3'h1 : 3'h0;
	end
endmodule // csc_far_side

// ===== test/tb_capacitive_sense_counter.sv
// Purpose: self-checking bench for the capacitive sense counter
// Assumes: one bus request at a time, far side from csc_far_side
// Notes:   pulse width and period counts are compared as differences to cancel start latency
`timescale 1ns/1ps
`include "csc_map.vh"
module tb_capacitive_sense_counter;
	logic        clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
	logic        osc_run = 0, cmp_lvl = 0, osc_q = 0;
	logic [7:0]  avs_address = 8'h00, q;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  be = 4'hF;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, cmp0, osc, seq;
	wire         pin_out, switch_clk, pit_on_prescaled, timer_tc;
	int          n_fail = 0, num_checks = 0, a, b, i, n;
	// divider code beside the carry period in clocks
	logic [13:0] rows [4] = '{14'h0100, 14'h1200, 14'h2400, 14'h3800};

	csc_counter dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
		.cmp0_in(cmp0), .cmp1_in(1'b0), .relaxation_oscillator_in(osc),
		.low_speed_oscillator_in(1'b0), .mux_bus_in(1'b0),
		.pseudo_random_sequencer_in(seq), .pit_start_in(1'b0),
		.internal_timer_in(1'b0), .pin_out, .switch_clk, .pit_on_prescaled,
		.timer_tc);
	csc_far_side far (.clk, .osc_run, .cmp_lvl, .osc, .cmp0, .seq);

	// clock, and oscillator history for edge counting
	initial forever #10 clk = ~clk;
	always @(posedge clk) osc_q <= osc;

	task chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task bus(input logic wr, input logic [7:0] ad, dat);
		avs_address <= ad;
		avs_writedata <= {24'h0, dat};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	// clocks from one rise of pin_out to the next
	task gap(output int c);
		while (pin_out !== 1'b0) @(posedge clk);
		while (pin_out !== 1'b1) @(posedge clk);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (pin_out !== 1'b0);
		while (pin_out !== 1'b1) begin
			@(posedge clk);
			c++;
		end
	endtask
	// oscillator rises seen until the terminal count reaches lv
	task ticks(input logic lv, output int c);
		c = 0;
		while (timer_tc !== lv) begin
			@(posedge clk);
			if (osc === 1'b1 && osc_q === 1'b0)
				c++;
		end
	endtask
	// two pulses of hi clocks, lo apart, then read the held low count
	task meas(input logic [1:0] md, input logic fl, input int hi, lo,
		output int c);
		cmp_lvl <= fl;
		bus(1, `CSC_IDX_CTRL_SEC, {4'h0, fl, 3'h0});
		bus(1, `CSC_IDX_CTRL_PRI, {5'h0, md, 1'b1});
		repeat (6) @(posedge clk);
		cmp_lvl <= !fl;
		repeat (hi) @(posedge clk);
		cmp_lvl <= fl;
		repeat (lo) @(posedge clk);
		cmp_lvl <= !fl;
		repeat (hi) @(posedge clk);
		cmp_lvl <= fl;
		repeat (8) @(posedge clk);
		bus(1, `CSC_IDX_CTRL_PRI, {5'h0, md, 1'b0});
		bus(0, `CSC_IDX_CNT_LO, 8'h00);
		c = q;
	endtask
	task close_out;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog well beyond the expected run of some 10000 clocks
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("watchdog expired");
		close_out;
	end

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		bus(0, `CSC_IDX_CTRL_PRI, 8'h00);
		chk(q, `CSC_RST_CTRL_PRI);
		be <= 4'h0;
		bus(1, `CSC_IDX_CTRL_SEC, 8'hFF);
		be <= 4'hF;
		bus(0, `CSC_IDX_CTRL_SEC, 8'h00);
		chk(q, `CSC_RST_CTRL_SEC);
		$display("test reset and registers done");
		// continuous mode, low carry on the pin, every divider code
		for (i = 0; i < 4; i++) begin
			bus(1, `CSC_IDX_CTRL_SEC, {1'b0, rows[i][13:12], 5'h0});
			bus(1, `CSC_IDX_CTRL_PRI, 8'h87);
			gap(n);
			chk(16'(n), {4'h0, rows[i][11:0]});
			bus(0, `CSC_IDX_STATUS, 8'h00);
			chk(q[6], 1'b1);
			bus(1, `CSC_IDX_CTRL_PRI, 8'h86);
			bus(0, `CSC_IDX_STATUS, 8'h00);
			chk(q, 8'h00);
			bus(0, `CSC_IDX_CNT_LO, 8'h00);
			chk(q, 8'h00);
		end
		$display("test continuous done");
		meas(2'h1, 1'b0, 8, 10, a);
		meas(2'h1, 1'b0, 20, 10, b);
		chk(16'(b - a), 16'd12);
		meas(2'h2, 1'b0, 8, 10, a);
		meas(2'h2, 1'b0, 8, 22, b);
		chk(16'(b - a), 16'd12);
		meas(2'h1, 1'b1, 8, 10, a);
		meas(2'h1, 1'b1, 20, 10, b);
		chk(16'(b - a), 16'd12);
		$display("test pulse width and period done");
		// one-shot timer on the oscillator, restarted by re-enable
		for (i = 0; i < 2; i++) begin
			bus(1, `CSC_IDX_TIMER, 8'(i * 5));
			bus(1, `CSC_IDX_CTRL_PRI, 8'h29);
			osc_run <= 1'b1;
			ticks(1'b1, n);
			chk(16'(n), 16'(i * 5 + 3));
			ticks(1'b0, n);
			chk(16'(n), 16'd1);
			b = 0;
			repeat (120) begin
				@(posedge clk);
				if (timer_tc !== 1'b0)
					b = 1;
			end
			chk(16'(b), 16'd0);
			bus(1, `CSC_IDX_CTRL_PRI, 8'h28);
			// keep the oscillator up so the disable reaches the timer
			repeat (40) @(posedge clk);
			osc_run <= 1'b0;
		end
		$display("test timer done");
		close_out;
	end
endmodule // tb_capacitive_sense_counter
